// File: common/epi_pkg.sv
package epi_pkg;
	// register byte addresses on the bus
	localparam logic [7:0] ADDR_MCU_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_CTRL_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
	localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h0C;
	localparam logic [7:0] ADDR_CORE_STATUS = 8'h10;
	localparam logic [7:0] ADDR_SLEEP_STATUS = 8'h14;
	// mcu_control field positions
	localparam int A_SENSE_LO = 0;
	localparam int B_SENSE_LO = 2;
	localparam int SLEEP_SEL0 = 4;
	localparam int SLEEP_SEL1 = 5;
	localparam int SLEEP_EN = 6;
	localparam int SLEEP_SEL2 = 7;
	// mcu_control_status, mask and flag positions
	localparam int C_EDGE_BIT = 6;
	localparam int LINE_B_BIT = 7;
	localparam int LINE_A_BIT = 6;
	localparam int LINE_C_BIT = 5;
	localparam int GIE_BIT = 7;
	localparam logic [7:0] REG_RESET = 8'h00;
	// sense encodings
	localparam logic [1:0] SENSE_LOW = 2'h0;
	localparam logic [1:0] SENSE_ANY = 2'h1;
	localparam logic [1:0] SENSE_FALL = 2'h2;
	localparam logic [1:0] SENSE_RISE = 2'h3;
	// sleep modes
	localparam logic [2:0] SLEEP_IDLE = 3'h0;
	localparam logic [2:0] SLEEP_PDOWN = 3'h2;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// wake timing
	localparam int WDT_PERIOD_NS = 1000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int WDT_CYCLES = WDT_PERIOD_NS / CLK_PERIOD_NS;
	localparam int STARTUP_NS = 4000;
	localparam int STARTUP_CYCLES = STARTUP_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		WK_AWAKE = 2'b00,
		WK_SAMPLE = 2'b01,
		WK_START = 2'b11
	} epi_wake_t;

	typedef struct packed {
		logic line_b;
		logic line_a;
		logic line_c;
	} epi_lines_t;
endpackage

// File: dv/epi_pin_src.sv
`timescale 1ns/1ps
// stand-in for the sources on the interrupt pins; pins idle high
module epi_pin_src (
	// clock
	input wire logic sys_clk,
	// driven pins
	output epi_pkg::epi_lines_t pin_q
);
	// idle level from time zero, so the preset synchronisers see no edge
	initial pin_q = 3'h7;

	// move one pin just after an edge
	task automatic drive(input int idx, input logic v);
		pin_q[idx] <= v;
	endtask

	// hold low level
	// a slow source: low for a fixed span, then released to idle
	task automatic hold_low(input int idx, input int cyc);
		pin_q[idx] <= 1'b0;
		repeat (cyc) @(posedge sys_clk);
		pin_q[idx] <= 1'b1;
	endtask
endmodule // epi_pin_src

// File: dv/tb_external_pin_interrupts.sv
`timescale 1ns/1ps
module tb_external_pin_interrupts;
	// bench driven inputs, all valued at time zero
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic sleep_req = 1'b0;
	epi_pkg::epi_lines_t irq_ack = 3'h0;
	// design outputs and bench state
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, io_clk_en_q, asleep_q;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [31:0] s_axi_rdata, rd;
	epi_pkg::epi_lines_t ext_irq_pin, irq_take_q;
	int error_cnt = 0;
	int cmp_count = 0;

	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;

	// short wake counts keep the sleep scenarios brief
	epi_ext_irq #(.WDT_CYC(4), .STARTUP_CYC(8)) dut_u (.sys_clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .ext_irq_pin, .irq_ack, .sleep_req, .irq_take_q, .io_clk_en_q, .asleep_q);
	epi_pin_src src_u (.sys_clk, .pin_q(ext_irq_pin));

	// compare helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// bus write: each valid dropped at the edge its ready is seen, bready held until bvalid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 100);
		// a wait that runs out counts as a mismatch here
		cb(s_axi_bvalid, 1'b1);
		chk({30'h0, s_axi_bresp}, {30'h0, epi_pkg::RESP_OKAY});
		s_axi_bready <= 1'b0;
		// let an edge pass so a following write never re-raises bready in this step
		@(posedge sys_clk);
	endtask

	// bus read: data taken at the edge where rvalid is seen
	task automatic rd_reg(input logic [7:0] a);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 100);
		cb(s_axi_rvalid, 1'b1);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		rd_reg(a);
		chk(rd, exp);
		chk({30'h0, rs}, {30'h0, epi_pkg::RESP_OKAY});
	endtask

	// falling then rising level change on one pin, flag checked after each
	task automatic edge_pair(input int pi, input int fb, input logic ef, input logic er);
		wr(epi_pkg::ADDR_IRQ_FLAGS, 8'hE0);
		src_u.drive(pi, 1'b0);
		wt(5);
		rdchk(epi_pkg::ADDR_IRQ_FLAGS, 32'(ef) << fb);
		wr(epi_pkg::ADDR_IRQ_FLAGS, 8'hE0);
		src_u.drive(pi, 1'b1);
		wt(5);
		rdchk(epi_pkg::ADDR_IRQ_FLAGS, 32'(er) << fb);
	endtask

	// sleep entry, handler acknowledge and bounded wait for wake
	task automatic slp;
		sleep_req <= 1'b1;
		wt(1);
		sleep_req <= 1'b0;
		wt(3);
	endtask
	task automatic ack(input logic [2:0] x);
		irq_ack <= x;
		wt(1);
		irq_ack <= 3'h0;
	endtask
	task automatic awake;
		int n;
		n = 0;
		while (asleep_q !== 1'b0 && n < 200) begin
			wt(1);
			n++;
		end
		cb(asleep_q, 1'b0);
	endtask

	// control register reset, read/write and an unmapped address
	task automatic t_regs;
		rdchk(epi_pkg::ADDR_MCU_CONTROL, 32'h0);
		wr(epi_pkg::ADDR_MCU_CONTROL, 8'hFF);
		rdchk(epi_pkg::ADDR_MCU_CONTROL, 32'hFF);
		wr(epi_pkg::ADDR_MCU_CONTROL, 8'h00);
		rd_reg(8'h40);
		chk({30'h0, rs}, {30'h0, epi_pkg::RESP_SLVERR});
		chk(rd, 32'h0);
	endtask

	// every edge sense code on lines a and b, then both edges of line c
	task automatic t_edges;
		for (int ln = 0; ln < 2; ln++) begin
			for (int m = 1; m < 4; m++) begin
				wr(epi_pkg::ADDR_MCU_CONTROL, 8'(m << (2 * ln)));
				edge_pair(ln + 1, epi_pkg::LINE_A_BIT + ln, m != 3, m != 2);
			end
		end
		for (int e = 0; e < 2; e++) begin
			wr(epi_pkg::ADDR_CTRL_STATUS, 8'(e << epi_pkg::C_EDGE_BIT));
			edge_pair(0, epi_pkg::LINE_C_BIT, e == 0, e == 1);
		end
		wr(epi_pkg::ADDR_CTRL_STATUS, 8'h00);
	endtask

	// level request, mask and global enable gating, handler clear
	task automatic t_gate;
		wr(epi_pkg::ADDR_MCU_CONTROL, 8'h08);
		wr(epi_pkg::ADDR_CORE_STATUS, 8'h80);
		wr(epi_pkg::ADDR_IRQ_MASK, 8'h40);
		wr(epi_pkg::ADDR_IRQ_FLAGS, 8'hE0);
		src_u.drive(1, 1'b0);
		wt(5);
		repeat (8) begin
			cb(irq_take_q.line_a, 1'b1);
			wt(1);
		end
		rdchk(epi_pkg::ADDR_IRQ_FLAGS, 32'h0);
		wr(epi_pkg::ADDR_IRQ_MASK, 8'h00);
		wt(3);
		cb(irq_take_q.line_a, 1'b0);
		src_u.drive(1, 1'b1);
		src_u.drive(2, 1'b0);
		wt(5);
		cb(irq_take_q.line_b, 1'b0);
		wr(epi_pkg::ADDR_IRQ_MASK, 8'h80);
		wt(3);
		cb(irq_take_q.line_b, 1'b1);
		wr(epi_pkg::ADDR_CORE_STATUS, 8'h00);
		wt(3);
		cb(irq_take_q.line_b, 1'b0);
		wr(epi_pkg::ADDR_CORE_STATUS, 8'h80);
		ack(3'h4);
		wt(3);
		cb(irq_take_q.line_b, 1'b0);
		rdchk(epi_pkg::ADDR_IRQ_FLAGS, 32'h0);
		src_u.drive(2, 1'b1);
		wt(5);
	endtask

	// power-down and idle sleep, edge and level wake-up
	task automatic t_sleep;
		wr(epi_pkg::ADDR_IRQ_MASK, 8'h60);
		wr(epi_pkg::ADDR_MCU_CONTROL, 8'h62);
		wr(epi_pkg::ADDR_IRQ_FLAGS, 8'hE0);
		slp();
		cb(io_clk_en_q, 1'b0);
		rdchk(epi_pkg::ADDR_SLEEP_STATUS, {29'h0, 1'b0, epi_pkg::WK_SAMPLE});
		src_u.drive(1, 1'b0);
		wt(8);
		cb(irq_take_q.line_a, 1'b0);
		cb(asleep_q, 1'b1);
		src_u.drive(1, 1'b1);
		wt(4);
		src_u.drive(0, 1'b0);
		awake();
		cb(irq_take_q.line_c, 1'b1);
		src_u.drive(0, 1'b1);
		ack(3'h1);
		wr(epi_pkg::ADDR_MCU_CONTROL, 8'h42);
		slp();
		cb(io_clk_en_q, 1'b1);
		rdchk(epi_pkg::ADDR_SLEEP_STATUS, {29'h0, 1'b1, epi_pkg::WK_SAMPLE});
		src_u.drive(1, 1'b0);
		awake();
		cb(irq_take_q.line_a, 1'b1);
		src_u.drive(1, 1'b1);
		ack(3'h2);
		wr(epi_pkg::ADDR_MCU_CONTROL, 8'h60);
		slp();
		src_u.drive(1, 1'b0);
		awake();
		wt(2);
		cb(irq_take_q.line_a, 1'b1);
		src_u.drive(1, 1'b1);
		wt(4);
		// level gone after both samples but before start-up ends
		slp();
		src_u.hold_low(1, 11);
		awake();
		wt(2);
		cb(irq_take_q.line_a, 1'b0);
		wr(epi_pkg::ADDR_MCU_CONTROL, 8'h00);
	endtask

	// the only place the run ends
	task automatic conclude;
		$display("mismatches=%0d compares=%0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// reset for five cycles, then the scenarios
	initial begin
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		t_regs();
		t_edges();
		t_gate();
		t_sleep();
		conclude();
	end

	// watchdog well beyond the several hundred cycles the scenarios need
	initial begin
		#100000;
		error_cnt++;
		conclude();
	end
endmodule // tb_external_pin_interrupts

// File: src/epi_edge_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser with previous-sample edge compare
module epi_edge_sync (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// pin and results
	input wire logic pin,
	output logic level_q,
	output logic rise,
	output logic fall
);
	logic meta_q;
	logic prev_q;

	// (R18) sync then compare
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			meta_q <= 1'b1;
			level_q <= 1'b1;
			prev_q <= 1'b1;
		end else begin
			meta_q <= pin;
			level_q <= meta_q;
			prev_q <= level_q;
		end
	end

	// edges seen between two settled samples
	assign rise = level_q & ~prev_q;
	assign fall = ~level_q & prev_q;
endmodule // epi_edge_sync

// File: src/epi_ext_irq.sv
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
// Summary of operation
// (R1) pin activity raises requests even when the pin is driven as output
// (R2) line c senses edges only, no level mode
// (R3) lines a/b in low-level mode request continuously while pin is low
// (R4) a/b edge detection runs on the I/O clock only
// (R5) a/b low level and line c edges work without the I/O clock
// (R6) I/O clock stops in every sleep mode except idle
// (R7) power-down level wake needs two watchdog-clock samples of the level
// (R8) level gone before startup ends: wake completes, no level interrupt
// (R9) line b taken only with global enable and its mask bit
// (R10) line b sense field bits 3:2: low, any, falling, rising
// (R11) line a sense field bits 1:0: low, any, falling, rising
// (R12) pins sampled before edge detect; pulses over one clock period caught
// (R13) source holds low level until current instruction completes
// (R14) line a taken only with global enable and its mask bit
// (R15) control register eight bits, all read/write, reset to zero
// (R16) flags set on events, cleared by handler or writing one; level reads zero
// (R17) line c edge bit: zero falling, one rising
// (R18) pins pass two-stage synchroniser and previous-sample compare
module epi_ext_irq #(
	parameter int WDT_CYC = epi_pkg::WDT_CYCLES,
	parameter int STARTUP_CYC = epi_pkg::STARTUP_CYCLES
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// axi4-lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// interrupt pins, read whatever the pin direction
	input wire epi_pkg::epi_lines_t ext_irq_pin,
	// core side
	input wire epi_pkg::epi_lines_t irq_ack,
	input wire logic sleep_req,
	output epi_pkg::epi_lines_t irq_take_q,
	output logic io_clk_en_q,
	output logic asleep_q
);
	logic [7:0] mcu_control_q;
	logic [7:0] mcu_control_status_q;
	logic [7:0] general_irq_mask_q;
	logic [7:0] core_status_word_q;
	epi_pkg::epi_lines_t flag_q;
	epi_pkg::epi_wake_t wake_q;
	logic [15:0] wake_cnt_q;
	logic [1:0] wake_smp_q;
	logic have_aw_q;
	logic have_w_q;
	logic [7:0] aw_q;
	logic [31:0] wd_q;
	logic [3:0] ws_q;
	epi_pkg::epi_lines_t rise;
	epi_pkg::epi_lines_t fall;
	epi_pkg::epi_lines_t lvl;
	logic [1:0] sense_a;
	logic [1:0] sense_b;
	epi_pkg::epi_lines_t event_v;
	epi_pkg::epi_lines_t level_req;
	epi_pkg::epi_lines_t clr_wr;
	logic wr_go;
	logic gie;
	logic level_wake;
	logic [2:0] sleep_mode;

	// (R12) sample before edges
	// one synchroniser per pin
	epi_edge_sync u_sync_a (.sys_clk(sys_clk), .srst(srst), .pin(ext_irq_pin.line_a),
		.level_q(lvl.line_a), .rise(rise.line_a), .fall(fall.line_a));
	epi_edge_sync u_sync_b (.sys_clk(sys_clk), .srst(srst), .pin(ext_irq_pin.line_b),
		.level_q(lvl.line_b), .rise(rise.line_b), .fall(fall.line_b));
	epi_edge_sync u_sync_c (.sys_clk(sys_clk), .srst(srst), .pin(ext_irq_pin.line_c),
		.level_q(lvl.line_c), .rise(rise.line_c), .fall(fall.line_c));

	// decode a two-bit sense field against pin history
	function automatic logic sense_hit(input logic [1:0] s, input logic r, input logic f, input logic en);
		logic hit;
		hit = 1'b0;
		unique case (s)
			epi_pkg::SENSE_LOW: hit = 1'b0;
			epi_pkg::SENSE_ANY: hit = r | f;
			epi_pkg::SENSE_FALL: hit = f;
			epi_pkg::SENSE_RISE: hit = r;
		endcase
		return hit & en;
	endfunction

	// (R10) line b field
	assign sense_b = mcu_control_q[epi_pkg::B_SENSE_LO +: 2];
	// (R11) line a field
	assign sense_a = mcu_control_q[epi_pkg::A_SENSE_LO +: 2];
	assign gie = core_status_word_q[epi_pkg::GIE_BIT];
	// sleep select bits are not adjacent in the register, so gather them once
	assign sleep_mode = {mcu_control_q[epi_pkg::SLEEP_SEL2], mcu_control_q[epi_pkg::SLEEP_SEL1],
		mcu_control_q[epi_pkg::SLEEP_SEL0]};

	// (R4) edges only counted while io clock runs
	assign event_v.line_a = sense_hit(sense_a, rise.line_a, fall.line_a, io_clk_en_q);
	assign event_v.line_b = sense_hit(sense_b, rise.line_b, fall.line_b, io_clk_en_q);
	// (R5) line c edge works without io clock
	// (R17) edge polarity bit
	assign event_v.line_c = mcu_control_status_q[epi_pkg::C_EDGE_BIT] ? rise.line_c : fall.line_c;

	// (R3) level request follows the pin; (R2) never on line c
	assign level_req.line_a = (sense_a == epi_pkg::SENSE_LOW) & ~lvl.line_a;
	assign level_req.line_b = (sense_b == epi_pkg::SENSE_LOW) & ~lvl.line_b;
	assign level_req.line_c = 1'b0;

	// write-one-to-clear from the flag register
	assign wr_go = have_aw_q & have_w_q & ~s_axi_bvalid;
	assign clr_wr.line_b = wr_go & (aw_q == epi_pkg::ADDR_IRQ_FLAGS) & ws_q[0] & wd_q[epi_pkg::LINE_B_BIT];
	assign clr_wr.line_a = wr_go & (aw_q == epi_pkg::ADDR_IRQ_FLAGS) & ws_q[0] & wd_q[epi_pkg::LINE_A_BIT];
	assign clr_wr.line_c = wr_go & (aw_q == epi_pkg::ADDR_IRQ_FLAGS) & ws_q[0] & wd_q[epi_pkg::LINE_C_BIT];

	// (R16) sticky flags, set beats clear, level mode forces zero
	// (R1) pin taps ignore direction
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			flag_q <= '0;
		end else begin
			flag_q <= (flag_q & ~clr_wr & ~irq_ack) | event_v;
			if (sense_a == epi_pkg::SENSE_LOW) begin
				flag_q.line_a <= 1'b0;
			end
			if (sense_b == epi_pkg::SENSE_LOW) begin
				flag_q.line_b <= 1'b0;
			end
		end
	end

	// (R8) level interrupt held back until awake
	// (R9) line b gated by global enable and mask
	// (R14) line a gated likewise
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			irq_take_q <= '0;
		end else begin
			irq_take_q.line_b <= gie & general_irq_mask_q[epi_pkg::LINE_B_BIT]
				& (flag_q.line_b | (level_req.line_b & ~asleep_q));
			irq_take_q.line_a <= gie & general_irq_mask_q[epi_pkg::LINE_A_BIT]
				& (flag_q.line_a | (level_req.line_a & ~asleep_q));
			irq_take_q.line_c <= gie & general_irq_mask_q[epi_pkg::LINE_C_BIT] & flag_q.line_c;
		end
	end

	// low-level requests on lines a and b that can wake a deep sleep
	assign level_wake = (level_req.line_a & general_irq_mask_q[epi_pkg::LINE_A_BIT])
		| (level_req.line_b & general_irq_mask_q[epi_pkg::LINE_B_BIT]);

	// sleep and wake sequencing; startup runs even if the level goes away
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wake_q <= epi_pkg::WK_AWAKE;
			wake_cnt_q <= '0;
			wake_smp_q <= '0;
			asleep_q <= 1'b0;
		end else begin
			unique case (wake_q)
				epi_pkg::WK_AWAKE: begin
					if (sleep_req & mcu_control_q[epi_pkg::SLEEP_EN]) begin
						asleep_q <= 1'b1;
						wake_q <= epi_pkg::WK_SAMPLE;
						wake_cnt_q <= '0;
						wake_smp_q <= '0;
					end
				end
				epi_pkg::WK_SAMPLE: begin
					// (R7) two watchdog ticks of the level
					if (wake_cnt_q == 16'(WDT_CYC - 1)) begin
						wake_cnt_q <= '0;
						wake_smp_q <= level_wake ? wake_smp_q + 2'h1 : 2'h0;
						if (level_wake & wake_smp_q == 2'h1) begin
							wake_q <= epi_pkg::WK_START;
						end
					end else begin
						wake_cnt_q <= wake_cnt_q + 16'h1;
					end
					if (|(flag_q & general_irq_mask_q[epi_pkg::LINE_B_BIT -: 3])) begin
						wake_q <= epi_pkg::WK_START;
						wake_cnt_q <= '0;
					end
				end
				epi_pkg::WK_START: begin
					if (wake_cnt_q == 16'(STARTUP_CYC - 1)) begin
						wake_q <= epi_pkg::WK_AWAKE;
						asleep_q <= 1'b0;
						wake_cnt_q <= '0;
					end else begin
						wake_cnt_q <= wake_cnt_q + 16'h1;
					end
				end
			endcase
		end
	end

	// (R6) io clock stops outside idle
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			io_clk_en_q <= 1'b1;
		end else begin
			io_clk_en_q <= ~asleep_q | (sleep_mode == epi_pkg::SLEEP_IDLE);
		end
	end

	// axi write capture: address and data in either order
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			have_aw_q <= 1'b0;
			have_w_q <= 1'b0;
			aw_q <= '0;
			wd_q <= '0;
			ws_q <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= epi_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				have_aw_q <= 1'b1;
				aw_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				have_w_q <= 1'b1;
				wd_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				have_aw_q <= 1'b0;
				have_w_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_q > epi_pkg::ADDR_SLEEP_STATUS || aw_q[1:0] != 2'h0)
					? epi_pkg::RESP_SLVERR : epi_pkg::RESP_OKAY;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// write readies registered: each tracks its holding flag and bvalid one edge ahead,
	// so the bus sees the same timing as a gate would give, but from a flip-flop
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end else if (wr_go) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_bvalid) begin
			s_axi_awready <= s_axi_bready;
			s_axi_wready <= s_axi_bready;
		end else begin
			s_axi_awready <= ~have_aw_q & ~(s_axi_awvalid & s_axi_awready);
			s_axi_wready <= ~have_w_q & ~(s_axi_wvalid & s_axi_wready);
		end
	end

	// (R15) control registers, low byte lane only
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			mcu_control_q <= epi_pkg::REG_RESET;
			mcu_control_status_q <= epi_pkg::REG_RESET;
			general_irq_mask_q <= epi_pkg::REG_RESET;
			core_status_word_q <= epi_pkg::REG_RESET;
		end else if (wr_go & ws_q[0]) begin
			unique case (aw_q)
				epi_pkg::ADDR_MCU_CONTROL: mcu_control_q <= wd_q[7:0];
				epi_pkg::ADDR_CTRL_STATUS: mcu_control_status_q <= wd_q[7:0];
				epi_pkg::ADDR_IRQ_MASK: general_irq_mask_q <= wd_q[7:0];
				epi_pkg::ADDR_CORE_STATUS: core_status_word_q <= wd_q[7:0];
				default: ;
			endcase
		end
	end

	// axi read: one cycle from address to data
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
			s_axi_rdata <= '0;
			s_axi_rresp <= epi_pkg::RESP_OKAY;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_arready <= 1'b0;
			s_axi_rresp <= epi_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				epi_pkg::ADDR_MCU_CONTROL: s_axi_rdata <= {24'h0, mcu_control_q};
				epi_pkg::ADDR_CTRL_STATUS: s_axi_rdata <= {24'h0, mcu_control_status_q};
				epi_pkg::ADDR_IRQ_MASK: s_axi_rdata <= {24'h0, general_irq_mask_q};
				epi_pkg::ADDR_IRQ_FLAGS: s_axi_rdata <= {24'h0, flag_q, 5'h0};
				epi_pkg::ADDR_CORE_STATUS: s_axi_rdata <= {24'h0, core_status_word_q};
				epi_pkg::ADDR_SLEEP_STATUS: s_axi_rdata <= {29'h0, io_clk_en_q, wake_q};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= epi_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// checks
	AST_C_RISE: assert property (@(posedge sys_clk) disable iff (srst) // (R17)
		mcu_control_status_q[epi_pkg::C_EDGE_BIT] & rise.line_c |=> flag_q.line_c)
		else $error("line c rising edge lost");
	AST_LEVEL_ZERO: assert property (@(posedge sys_clk) disable iff (srst) // (R16)
		sense_a == epi_pkg::SENSE_LOW && $stable(sense_a) |=> !flag_q.line_a)
		else $error("level mode flag set");
	AST_B_GATE: assert property (@(posedge sys_clk) disable iff (srst) // (R9)
		irq_take_q.line_b |-> $past(gie) && $past(general_irq_mask_q[epi_pkg::LINE_B_BIT]))
		else $error("line b taken while masked");
	AST_A_GATE: assert property (@(posedge sys_clk) disable iff (srst) // (R14)
		irq_take_q.line_a |-> $past(gie) && $past(general_irq_mask_q[epi_pkg::LINE_A_BIT]))
		else $error("line a taken while masked");
	AST_A_LEVEL: assert property (@(posedge sys_clk) disable iff (srst) // (R3)
		gie && general_irq_mask_q[epi_pkg::LINE_A_BIT] && level_req.line_a && !asleep_q |=> irq_take_q.line_a)
		else $error("low level not requesting");
	AST_B_FALL: assert property (@(posedge sys_clk) disable iff (srst) // (R10)
		sense_b == epi_pkg::SENSE_FALL && fall.line_b && io_clk_en_q |=> flag_q.line_b)
		else $error("line b falling edge lost");
	AST_A_RISE: assert property (@(posedge sys_clk) disable iff (srst) // (R11)
		sense_a == epi_pkg::SENSE_RISE && fall.line_a && !rise.line_a && !flag_q.line_a |=> !flag_q.line_a)
		else $error("line a rise mode took a fall");
	AST_NO_IO_EDGE: assert property (@(posedge sys_clk) disable iff (srst) // (R4)
		!io_clk_en_q && !flag_q.line_a |=> !flag_q.line_a || $past(sense_a) == epi_pkg::SENSE_LOW)
		else $error("edge seen without io clock");
	AST_C_NO_LEVEL: assert property (@(posedge sys_clk) disable iff (srst) // (R2)
		!flag_q.line_c && !rise.line_c && !fall.line_c |=> !flag_q.line_c)
		else $error("line c set without edge");
	AST_A_ANY: assert property (@(posedge sys_clk) disable iff (srst) // (R11)
		sense_a == epi_pkg::SENSE_ANY && (rise.line_a || fall.line_a) && io_clk_en_q |=> flag_q.line_a)
		else $error("line a change lost");
	AST_C_FALL: assert property (@(posedge sys_clk) disable iff (srst) // (R17)
		!mcu_control_status_q[epi_pkg::C_EDGE_BIT] && fall.line_c |=> flag_q.line_c)
		else $error("line c falling edge lost");
	AST_IO_STOP: assert property (@(posedge sys_clk) disable iff (srst) // (R6)
		asleep_q && sleep_mode != epi_pkg::SLEEP_IDLE |=> !io_clk_en_q)
		else $error("io clock running in deep sleep");
endmodule // epi_ext_irq
